//--- ebm_block_ram.sv
// 4 kbit embedded memory block with separate write and read ports
`timescale 1ns/1ns
`include "ebm_consts.svh"

// Notes on behaviour
// - One array of exactly 4 kbit, shared by every shape.
// - 256x16: 8-bit addresses, 16-bit data, 16-bit write inhibit.
// - 512x8: 9-bit addresses, 8-bit data, inhibit input unused.
// - 1024x4: 10-bit addresses, 4-bit data, inhibit input unused.
// - 2048x2: 11-bit addresses, 2-bit data, inhibit input unused.
// - Inhibit bit 0 stores that data bit; 1 keeps old content.
// - Data and addresses are registered at the array input first.
// - Write port acts on rising edge, falling edge when selected.
// - Read port acts on rising edge, falling edge when selected.
// - In 16-wide shape write address picks one of 256 words.
// - In 16-wide shape read address picks one of 256 words.
// - Contents may be preloaded while configuration is active.
// - Preload never sets location 0.
// - Independent ports serve single-port, dual-port or FIFO use.
module ebm_block_ram #(
  parameter ebm_pkg::ebm_shape_t SHAPE       = ebm_pkg::EBM_256X16,
  parameter bit                  WR_NEG_EDGE = 1'b0,
  parameter bit                  RD_NEG_EDGE = 1'b0,
  localparam int                 SH          = int'(SHAPE),
  localparam int                 AW          = `EBM_BASE_AW + SH,
  localparam int                 DW          = `EBM_FULL_DW >> SH,
  localparam int                 MW          = (SH == 0) ? `EBM_FULL_DW : 1
)(
  // system
  input  wire logic          clk,
  input  wire logic          rst_n,
  // write port
  input  wire logic          wrClk,
  input  wire logic          wrStrobe,
  input  wire logic          wrClockGate,
  input  wire logic [AW-1:0] wrLocation,
  input  wire logic [DW-1:0] wrData,
  input  wire logic [MW-1:0] wrMask,
  // read port
  input  wire logic          rdClk,
  input  wire logic          rdStrobe,
  input  wire logic          rdClockGate,
  input  wire logic [AW-1:0] rdLocation,
  output logic      [DW-1:0] rdData,
  // configuration preload
  input  wire logic          cfgActive,
  input  wire logic          cfgWrite,
  input  wire logic [7:0]    cfgLocation,
  input  wire logic [15:0]   cfgData
);

  logic [`EBM_FULL_DW-1:0] mem [`EBM_ROWS];

  // ports are fully independent, no shared address or clock
  logic wrEdge;
  logic rdEdge;

  ebm_port_edge #(
    .NEG_EDGE (WR_NEG_EDGE)
  ) u_wr_edge (
    .clk      (clk),
    .rst_n    (rst_n),
    .pinClk   (wrClk),
    .edgeSeen (wrEdge)
  );

  ebm_port_edge #(
    .NEG_EDGE (RD_NEG_EDGE)
  ) u_rd_edge (
    .clk      (clk),
    .rst_n    (rst_n),
    .pinClk   (rdClk),
    .edgeSeen (rdEdge)
  );

  ebm_pkg::ebm_wr_req_t wrPipe [`EBM_PIPE_DEPTH];
  ebm_pkg::ebm_rd_req_t rdPipe [`EBM_PIPE_DEPTH];
  ebm_pkg::ebm_wr_req_t wrReq;
  ebm_pkg::ebm_rd_req_t rdReq;
  logic                 wrCommit;
  logic                 rdPend;

  ebm_pkg::ebm_wr_req_t next_wrPipe [`EBM_PIPE_DEPTH];
  ebm_pkg::ebm_rd_req_t next_rdPipe [`EBM_PIPE_DEPTH];
  ebm_pkg::ebm_wr_req_t next_wrReq;
  ebm_pkg::ebm_rd_req_t next_rdReq;
  logic                 next_wrCommit;
  logic                 next_rdPend;
  logic [DW-1:0]        next_rdData;

  // array-side views of the held requests
  logic [7:0]              wrRow;
  logic [3:0]              wrLane;
  logic [7:0]              rdRow;
  logic [3:0]              rdLane;
  logic [`EBM_FULL_DW-1:0] wrBitEn;
  logic [`EBM_FULL_DW-1:0] wrSpread;
  logic [`EBM_FULL_DW-1:0] rdShifted;
  logic                    cfgStore;

  // row and lane of the write destination
  // row and lane of the read source
  always_comb begin
    wrRow  = ebm_pkg::ebm_row_of(wrReq.loc, SH);
    wrLane = ebm_pkg::ebm_lane_of(wrReq.loc, SH);
    rdRow  = ebm_pkg::ebm_row_of(rdReq.loc, SH);
    rdLane = ebm_pkg::ebm_lane_of(rdReq.loc, SH);
  end

  // per-bit enables from lane and inhibit
  // narrow shapes replicate data across lanes; only one lane is enabled
  always_comb begin
    wrBitEn  = `EBM_MASK_NONE;
    wrSpread = `EBM_MASK_NONE;
    for (int i = 0; i < `EBM_FULL_DW; i++) begin
      wrSpread[i] = wrReq.data[i % DW];
      wrBitEn[i]  = ((i / DW) == int'(wrLane)) && !wrReq.mask[i];
    end
  end

  // preload path, location 0 is skipped
  always_comb begin
    cfgStore = cfgActive && cfgWrite
               && ({3'h0, cfgLocation} != `EBM_LOC_ZERO);
  end

  // sampling pipes, input registers and read data, next values
  always_comb begin
    // pipes align pin data with the sampled clock pin
    next_wrPipe[0].act  = wrStrobe && wrClockGate;
    next_wrPipe[0].loc  = 11'(wrLocation);
    next_wrPipe[0].data = 16'(wrData);
    // full 16-bit inhibit in the 16-wide shape
    // inhibit has no effect outside 16-wide
    next_wrPipe[0].mask = (SH == 0) ? 16'(wrMask) : `EBM_MASK_NONE;
    next_rdPipe[0].act  = rdStrobe && rdClockGate;
    next_rdPipe[0].loc  = 11'(rdLocation);
    for (int i = 1; i < `EBM_PIPE_DEPTH; i++) begin
      next_wrPipe[i] = wrPipe[i-1];
      next_rdPipe[i] = rdPipe[i-1];
    end
    next_wrReq    = wrReq;
    next_rdReq    = rdReq;
    next_wrCommit = 1'b0;
    next_rdPend   = 1'b0;
    // capture at the active port edge
    if (wrEdge) begin
      next_wrReq = wrPipe[`EBM_PIPE_DEPTH-1];
    end
    if (rdEdge) begin
      next_rdReq = rdPipe[`EBM_PIPE_DEPTH-1];
    end
    // write needs enable and clock gate
    // user writes are dropped during configuration
    next_wrCommit = wrEdge && wrPipe[`EBM_PIPE_DEPTH-1].act && !cfgActive;
    // read needs strobe and clock gate
    next_rdPend   = rdEdge && rdPipe[`EBM_PIPE_DEPTH-1].act && !cfgActive;
    rdShifted     = 16'(mem[rdRow] >> (int'(rdLane) * DW));
    next_rdData   = rdPend ? rdShifted[DW-1:0] : rdData;
  end

  // port state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `EBM_PIPE_DEPTH; i++) begin
        wrPipe[i] <= '0;
        rdPipe[i] <= '0;
      end
      wrReq    <= '0;
      rdReq    <= '0;
      wrCommit <= 1'b0;
      rdPend   <= 1'b0;
      rdData   <= DW'(`EBM_RD_RESET);
    end else begin
      wrPipe   <= next_wrPipe;
      rdPipe   <= next_rdPipe;
      wrReq    <= next_wrReq;
      rdReq    <= next_rdReq;
      wrCommit <= next_wrCommit;
      rdPend   <= next_rdPend;
      rdData   <= next_rdData;
    end
  end

  // array writes; no reset, contents come from preload or the user
  // preload wins over a user commit landing in the same cycle; user writes otherwise are dropped during config
  always_ff @(posedge clk) begin
    if (cfgStore) begin
      mem[cfgLocation] <= cfgData;
    end else if (wrCommit) begin
      for (int i = 0; i < `EBM_FULL_DW; i++) begin
        if (wrBitEn[i]) begin
          mem[wrRow][i] <= wrSpread[i];
        end
      end
    end
  end

  // helper view of the row just written
  logic [`EBM_FULL_DW-1:0] wrRowNow;
  always_comb begin
    wrRowNow = mem[wrRow];
  end

  AST_SIZE_FIXED: assert property (
    @(posedge clk) disable iff (!rst_n)
    wrCommit |-> (`EBM_ROWS * `EBM_FULL_DW == `EBM_TOTAL_BITS)
                 && (AW + (4 - SH) == 12) && (DW << SH == 16))
    else $error("shape does not span exactly 4 kbit");

  AST_WRITE_CAUSE: assert property (
    @(posedge clk) disable iff (!rst_n)
    wrCommit |-> $past(wrEdge) && $past(wrPipe[3].act) && !$past(cfgActive))
    else $error("write committed without enabled active edge");

  AST_WRITE_CAPTURE: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(wrCommit) |-> wrReq == $past(wrPipe[3]))
    else $error("write request not taken from the edge sample");

  // rows never written hold unknowns; exact compare keeps them legal
  AST_INHIBIT_KEEPS: assert property (
    @(posedge clk) disable iff (!rst_n)
    wrCommit |=> ((mem[$past(wrRow)] & ~$past(wrBitEn))
                  === ($past(wrRowNow) & ~$past(wrBitEn))))
    else $error("inhibited bit changed during write");

  AST_ENABLED_STORES: assert property (
    @(posedge clk) disable iff (!rst_n)
    wrCommit && !cfgStore |=> ((mem[$past(wrRow)] & $past(wrBitEn))
                  == ($past(wrSpread) & $past(wrBitEn))))
    else $error("enabled bit not stored at addressed word");

  AST_ZERO_NOT_PRELOADED: assert property (
    @(posedge clk) disable iff (!rst_n)
    cfgActive && cfgWrite && cfgLocation == 8'h00 && !wrCommit
    |=> mem[0] === $past(mem[0]))
    else $error("preload changed location 0");

  AST_PRELOAD_STORES: assert property (
    @(posedge clk) disable iff (!rst_n)
    cfgStore |=> mem[$past(cfgLocation)] == $past(cfgData))
    else $error("preload word not stored");

  AST_READ_HOLDS: assert property (
    @(posedge clk) disable iff (!rst_n)
    !rdPend |=> rdData === $past(rdData))
    else $error("read data moved without an enabled read");

  AST_READ_SOURCE: assert property (
    @(posedge clk) disable iff (!rst_n)
    rdEdge && rdPipe[3].act && !cfgActive
    ##1 !wrCommit && !cfgStore
    |=> rdData === $past(rdShifted[DW-1:0]) && rdReq == $past(rdPipe[3], 2))
    else $error("read data not from captured read location");

  AST_WRITE_REFUSED_CFG: assert property (
    @(posedge clk) disable iff (!rst_n)
    cfgActive |=> !wrCommit)
    else $error("user write committed during configuration");

  AST_READ_REFUSED: assert property (
    @(posedge clk) disable iff (!rst_n)
    rdEdge && !rdPipe[3].act |=> !rdPend)
    else $error("read taken with strobe or clock gate low");

  AST_READ_CAPTURE: assert property (
    @(posedge clk) disable iff (!rst_n)
    rdEdge |=> rdReq == $past(rdPipe[3]))
    else $error("read request not taken from the edge sample");

  AST_REQ_HOLDS: assert property (
    @(posedge clk) disable iff (!rst_n)
    !wrEdge && !rdEdge |=> $stable(wrReq) && $stable(rdReq))
    else $error("held request changed without a port edge");

  AST_WIDE_ROW: assert property (
    @(posedge clk) disable iff (!rst_n)
    wrCommit && (SH == 0) |-> wrRow == wrReq.loc[7:0])
    else $error("16-wide write row differs from its address");

  AST_NARROW_NO_INHIBIT: assert property (
    @(posedge clk) disable iff (!rst_n)
    wrCommit && (SH != 0) |-> wrReq.mask == `EBM_MASK_NONE)
    else $error("inhibit applied outside the 16-wide shape");

  AST_ONE_LANE: assert property (
    @(posedge clk) disable iff (!rst_n)
    wrCommit |-> $countones(wrBitEn) <= DW)
    else $error("write enables more bits than one lane");

  AST_READ_ROW: assert property (
    @(posedge clk) disable iff (!rst_n)
    rdPend |-> rdRow == 8'(rdReq.loc >> SH))
    else $error("read row does not follow captured address");

  AST_ZERO_REFUSED: assert property (
    @(posedge clk) disable iff (!rst_n)
    cfgActive && cfgWrite && cfgLocation == 8'h00 |-> !cfgStore)
    else $error("preload accepted for location 0");

  COV_WRITE: cover property (@(posedge clk) disable iff (!rst_n)
    wrCommit);
  COV_MASKED_WRITE: cover property (@(posedge clk) disable iff (!rst_n)
    wrCommit && (wrReq.mask != `EBM_MASK_NONE));
  COV_READ: cover property (@(posedge clk) disable iff (!rst_n)
    rdPend ##1 rdData != $past(rdData));
  COV_PRELOAD_THEN_READ: cover property (@(posedge clk)
    disable iff (!rst_n) cfgStore ##[1:50] rdPend);

endmodule : ebm_block_ram

//--- ebm_consts.svh
// constants for the embedded memory block
`ifndef EBM_CONSTS_SVH
`define EBM_CONSTS_SVH

`define EBM_TOTAL_BITS  4096
`define EBM_ROWS        256
`define EBM_ROW_AW      8
`define EBM_BASE_AW     8
`define EBM_FULL_DW     16
`define EBM_MAX_AW      11
`define EBM_PIPE_DEPTH  4
`define EBM_LOC_ZERO    11'h000
`define EBM_RD_RESET    16'h0000
`define EBM_MASK_NONE   16'h0000

`endif

//--- ebm_pkg.sv
// types and address helpers for the embedded memory block
package ebm_pkg;

  // depth by width shapes, all sharing one 4 kbit array
  typedef enum {
    EBM_256X16,
    EBM_512X8,
    EBM_1024X4,
    EBM_2048X2
  } ebm_shape_t;

  // one write request as seen at the array input
  typedef struct packed {
    logic        act;
    logic [10:0] loc;
    logic [15:0] data;
    logic [15:0] mask;
  } ebm_wr_req_t;

  // one read request as seen at the array input
  typedef struct packed {
    logic        act;
    logic [10:0] loc;
  } ebm_rd_req_t;

  // storage row that holds a location
  function automatic logic [7:0] ebm_row_of(logic [10:0] loc, int sh);
    logic [10:0] t;
    t = loc >> sh;
    return t[7:0];
  endfunction : ebm_row_of

  // lane of the row that holds a location
  function automatic logic [3:0] ebm_lane_of(logic [10:0] loc, int sh);
    logic [10:0] t;
    t = loc & ((11'h001 << sh) - 11'h001);
    return t[3:0];
  endfunction : ebm_lane_of

endpackage : ebm_pkg

//--- ebm_port_edge.sv
// port clock edge detector: three-stage sampler, one-cycle pulse
`timescale 1ns/1ns

module ebm_port_edge #(
  parameter bit NEG_EDGE = 1'b0
)(
  // system
  input  wire logic clk,
  input  wire logic rst_n,
  // port clock pin and detected edge
  input  wire logic pinClk,
  output logic      edgeSeen
);

  logic s1;
  logic s2;
  logic s3;
  logic level;
  logic next_level;
  logic next_edgeSeen;

  // edge polarity pick
  // a change counts once s2 and s3 agree, so a one-cycle blip is dropped
  // level resets to the idle low pin, so no false edge follows reset
  always_comb begin
    next_level    = level;
    next_edgeSeen = 1'b0;
    if ((s2 == s3) && (s3 != level)) begin
      next_level    = s3;
      next_edgeSeen = NEG_EDGE ? !s3 : s3;
    end
  end

  // sampler chain, accepted level and registered pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1       <= 1'b0;
      s2       <= 1'b0;
      s3       <= 1'b0;
      level    <= 1'b0;
      edgeSeen <= 1'b0;
    end else begin
      s1       <= pinClk;
      s2       <= s1;
      s3       <= s2;
      level    <= next_level;
      edgeSeen <= next_edgeSeen;
    end
  end

  AST_EDGE_POLARITY: assert property (
    @(posedge clk) disable iff (!rst_n)
    edgeSeen |-> ($past(s2) == $past(s3)) && ($past(s3) != $past(level))
                 && ($past(s3) == !NEG_EDGE))
    else $error("edge pulse without a settled matching transition");

endmodule : ebm_port_edge

//--- ebm_user_model.sv
// fabric user logic model that drives both memory ports
`timescale 1ns/1ns

module ebm_user_model (
  // system
  input  wire logic clk,
  // write port
  output logic        wrClk,
  output logic        wrStrobe,
  output logic        wrClockGate,
  output logic [7:0]  wrLocation,
  output logic [15:0] wrData,
  output logic [15:0] wrMask,
  // read port
  output logic        rdClk,
  output logic        rdStrobe,
  output logic        rdClockGate,
  output logic [7:0]  rdLocation
);
  // idle state: port clocks low, controls off
  // write controls inactive
  initial begin
    {wrClk, wrStrobe, wrClockGate, rdClk, rdStrobe, rdClockGate} = 6'h00;
    {wrLocation, rdLocation} = 16'h0000;
    {wrData, wrMask} = 32'h0000_0000;
  end

  // one write: setup, 4-cycle high and low phases, then hold runs out
  task automatic wr(input logic en, input logic gate, input logic [7:0] loc,
                    input logic [15:0] d, input logic [15:0] m);
    @(posedge clk);
    {wrStrobe, wrClockGate} <= {en, gate};
    {wrLocation, wrData, wrMask} <= {loc, d, m};
    repeat (2) @(posedge clk);
    wrClk <= 1'b1;
    repeat (4) @(posedge clk);
    wrClk <= 1'b0;
    repeat (4) @(posedge clk);
    // stale values would hide a late capture, so show the inverse
    {wrLocation, wrData} <= {~loc, ~d};
    {wrStrobe, wrClockGate} <= 2'h0;
  endtask : wr

  // one read with the same phase lengths as a write
  task automatic rd(input logic en, input logic gate, input logic [7:0] loc);
    @(posedge clk);
    {rdStrobe, rdClockGate, rdLocation} <= {en, gate, loc};
    repeat (2) @(posedge clk);
    rdClk <= 1'b1;
    repeat (4) @(posedge clk);
    rdClk <= 1'b0;
    repeat (4) @(posedge clk);
    {rdStrobe, rdClockGate, rdLocation} <= {2'h0, ~loc};
  endtask : rd
endmodule : ebm_user_model

//--- ebm_block_ram_bench.sv
// self-checking bench for the embedded memory block, 256x16 and 512x8
`timescale 1ns/1ns

module ebm_block_ram_bench;
  logic        clk;
  logic        rst_n;
  logic        cfgActive;
  logic        cfgWrite;
  logic [7:0]  cfgLocation;
  logic [15:0] cfgData;
  logic        wrClk, wrStrobe, wrClockGate, rdClk, rdStrobe, rdClockGate;
  logic [7:0]  wrLocation, rdLocation;
  logic [15:0] wrData, wrMask, rdData;
  logic [7:0]  rdDataNarrow;
  int          errors;
  int          checks;

  // free-running 100 MHz system clock
  always #5 clk = ~clk;

  ebm_user_model usr (
    .clk(clk), .wrClk(wrClk), .wrStrobe(wrStrobe),
    .wrClockGate(wrClockGate), .wrLocation(wrLocation), .wrData(wrData),
    .wrMask(wrMask), .rdClk(rdClk), .rdStrobe(rdStrobe),
    .rdClockGate(rdClockGate), .rdLocation(rdLocation)
  );

  ebm_block_ram #(.SHAPE(ebm_pkg::EBM_256X16)) uut (
    .clk(clk), .rst_n(rst_n), .wrClk(wrClk), .wrStrobe(wrStrobe),
    .wrClockGate(wrClockGate), .wrLocation(wrLocation), .wrData(wrData),
    .wrMask(wrMask), .rdClk(rdClk), .rdStrobe(rdStrobe),
    .rdClockGate(rdClockGate), .rdLocation(rdLocation), .rdData(rdData),
    .cfgActive(cfgActive), .cfgWrite(cfgWrite),
    .cfgLocation(cfgLocation), .cfgData(cfgData)
  );

  // second block in the upper half, address steered here
  ebm_block_ram #(
    .SHAPE(ebm_pkg::EBM_512X8), .WR_NEG_EDGE(1'b1), .RD_NEG_EDGE(1'b1)
  ) uutNarrow (
    .clk(clk), .rst_n(rst_n), .wrClk(wrClk), .wrStrobe(wrStrobe),
    .wrClockGate(wrClockGate), .wrLocation({1'b1, wrLocation}),
    .wrData(wrData[7:0]), .wrMask(wrMask[0]), .rdClk(rdClk),
    .rdStrobe(rdStrobe), .rdClockGate(rdClockGate),
    .rdLocation({1'b1, rdLocation}), .rdData(rdDataNarrow),
    .cfgActive(cfgActive), .cfgWrite(cfgWrite),
    .cfgLocation(cfgLocation), .cfgData(cfgData)
  );

  // compare read data against a value worked out here
  task automatic chk(input logic [15:0] exp);
    checks++;
    if (rdData !== exp) begin
      errors++;
      $display("BAD %0t read data %h expected %h", $time, rdData, exp);
    end
  endtask : chk

  // falling-edge block answers two edges after the read task returns
  task automatic chkNarrow(input logic [7:0] exp);
    repeat (3) @(posedge clk);
    checks++;
    if (rdDataNarrow !== exp) begin
      errors++;
      $display("BAD %0t narrow read data %h expected %h", $time,
               rdDataNarrow, exp);
    end
  endtask : chkNarrow

  // read output is cleared by reset
  task automatic t_reset;
    @(posedge clk);
    chk(16'h0000);
  endtask : t_reset

  // masked writes keep inhibited bits; top word is reachable
  task automatic t_mask;
    usr.wr(1'b1, 1'b1, 8'h10, 16'hFFFF, 16'h0000);
    usr.wr(1'b1, 1'b1, 8'h10, 16'h1234, 16'h00FF);
    usr.wr(1'b1, 1'b1, 8'hFF, 16'hA5A5, 16'h0000);
    usr.rd(1'b1, 1'b1, 8'h10);
    chk(16'h12FF);
    usr.rd(1'b1, 1'b1, 8'hFF);
    chk(16'hA5A5);
  endtask : t_mask

  // strobe or gate low leaves memory and read data alone
  task automatic t_enables;
    usr.wr(1'b0, 1'b1, 8'h10, 16'h0F0F, 16'h0000);
    usr.wr(1'b1, 1'b0, 8'h10, 16'h0F0F, 16'h0000);
    usr.rd(1'b0, 1'b1, 8'h10);
    chk(16'hA5A5);
    usr.rd(1'b1, 1'b0, 8'h10);
    chk(16'hA5A5);
    usr.rd(1'b1, 1'b1, 8'h10);
    chk(16'h12FF);
  endtask : t_enables

  // preload skips row 0 and user writes are dropped meanwhile
  task automatic t_preload;
    usr.wr(1'b1, 1'b1, 8'h00, 16'hC0DE, 16'h0000);
    @(posedge clk);
    {cfgActive, cfgWrite, cfgLocation, cfgData} <= {2'h3, 8'h00, 16'h1111};
    @(posedge clk);
    {cfgLocation, cfgData} <= {8'h01, 16'h2222};
    @(posedge clk);
    cfgWrite <= 1'b0;
    usr.wr(1'b1, 1'b1, 8'h10, 16'h0000, 16'h0000);
    @(posedge clk);
    cfgActive <= 1'b0;
    usr.rd(1'b1, 1'b1, 8'h00);
    chk(16'hC0DE);
    usr.rd(1'b1, 1'b1, 8'h01);
    chk(16'h2222);
    usr.rd(1'b1, 1'b1, 8'h10);
    chk(16'h12FF);
  endtask : t_preload

  // byte lanes on falling edges; inhibit ignored in the narrow shape
  task automatic t_narrow;
    usr.wr(1'b1, 1'b1, 8'h20, 16'h00C3, 16'h0000);
    usr.wr(1'b1, 1'b1, 8'h21, 16'h005A, 16'hFFFF);
    usr.rd(1'b1, 1'b1, 8'h21);
    chkNarrow(8'h5A);
    usr.rd(1'b1, 1'b1, 8'h20);
    chkNarrow(8'hC3);
    chk(16'h00C3);
  endtask : t_narrow

  // single place where the run ends
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // watchdog against a hung sequence
  initial begin
    #200000;
    errors++;
    results();
  end

  // reset, then the scenarios in turn
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {cfgActive, cfgWrite, cfgLocation, cfgData} = 26'h0000000;
    errors = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_mask();
    t_enables();
    t_preload();
    t_narrow();
    results();
  end
endmodule : ebm_block_ram_bench
